// File: core/udcr_pkg.sv
// Package for the USB device initialization configuration register block
package udcr_pkg;
   // Command codes
   localparam logic [7:0] CMD_EPCFG_WR_BASE = 8'h20; // Endpoint config write, 16 codes
   localparam logic [7:0] CMD_EPCFG_RD_BASE = 8'h30; // Endpoint config read, 16 codes
   localparam logic [7:0] CMD_ADDR_WR = 8'hb6;
   localparam logic [7:0] CMD_ADDR_RD = 8'hb7;
   localparam logic [7:0] CMD_MODE_WR = 8'hb8;
   localparam logic [7:0] CMD_MODE_RD = 8'hb9;
   localparam logic [7:0] CMD_STATUS_RD_BASE = 8'h50; // Status read, clears bits
   localparam logic [7:0] CMD_STATUS_CHK_BASE = 8'hd0; // Status check, no side effects
   localparam logic [3:0] CMD_GROUP_MASK_HI = 4'hf;
   // Endpoint count and index of the last endpoint
   localparam int NUM_EP = 16;
   localparam logic [3:0] EP_LAST = 4'hf;
   // Endpoint configuration field positions
   localparam int EPC_FIFO_EN = 7;
   localparam int EPC_DIR = 6;
   localparam int EPC_DBL = 5;
   localparam int EPC_ISO = 4;
   localparam logic [7:0] EPC_RESET = 8'h00;
   // Address register field positions
   localparam int ADR_DEV_EN = 7;
   localparam logic [7:0] ADR_RESET = 8'h00;
   // Mode register field positions
   localparam int MOD_DMA_WD = 7;
   localparam int MOD_SUSP = 5;
   localparam int MOD_IRQ_EN = 3;
   localparam int MOD_DBG = 2;
   localparam int MOD_PULLUP = 0;
   localparam logic [7:0] MOD_RESET = 8'h00;
   // Bits kept over a bus reset: 7, 3, 2, 1, 0
   localparam logic [7:0] MOD_BUSRST_KEEP = 8'h8f;
   // Host port command strobe group
   typedef struct packed {
      logic cmd_valid; // One-cycle pulse: command phase
      logic [7:0] cmd_code;
      logic wr_valid; // One-cycle pulse: write data word
      logic [15:0] wr_data;
      logic rd_req; // One-cycle pulse: read data word
   } udcr_host_s;
   // Endpoint event inputs from the serial engine
   typedef struct packed {
      logic ack_evt;
      logic nak_evt;
      logic err_evt;
      logic xfer_evt;
      logic [3:0] ep_idx;
   } udcr_evt_s;
   // States of the command decoder
   typedef enum logic [1:0] {
      UDCR_IDLE = 2'b00,
      UDCR_WAIT_WR = 2'b01,
      UDCR_ALLOC = 2'b10
   } udcr_state_e;
endpackage : udcr_pkg

// File: core/udcr_regs.sv
// Initialization command register bank of a full-speed USB device controller
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - 16-bit port: N bytes take (N+1)/2 words
// - 8-bit register read: upper byte invalid
// - Check-status returns status copy, no clearing
// - Bus reset disables every endpoint
// - FIFO allocation starts after endpoint 15 written
// - Memory-affecting change invalidates all FIFO contents
// - Codes 20-2F write, 30-3F read configs
// - Bit7 enable, bit5 double, bit4 isochronous
// - Bit6 endpoint and DMA direction
// - Bus reset: internal address zero, enabled
// - New address active after status acknowledge
// - Address register: enable bit7, address 6:0
// - Mode register one byte, upper ignored
// - Mode bit7 selects DMA width
// - Suspend on mode bit5 one then zero
// - Mode bit3 gates every interrupt
// - Bit2 selects NAK/error or ACK/transfer interrupts
// - Soft pull-up ignored when external pull-up
// - Mode resets zero; bus reset keeps some
module udcr_regs #(
   parameter logic [63:0] FIFO_SIZE_TABLE = 64'hfedcba9876543210 // Size code per selector, plain default
) (
   input wire logic clk,
   input wire logic resetn,
   input wire udcr_pkg::udcr_host_s host, // Command port strobes
   input wire logic bus_16bit, // Host port width strap (level)
   input wire logic usb_bus_reset, // One-cycle pulse from the serial engine
   input wire logic status_ack, // Host acknowledged the zero-length status packet
   input wire logic external_pullup_flag, // From the hardware configuration register
   input wire logic [7:0] ep_status_in, // Status of the addressed endpoint
   input wire udcr_pkg::udcr_evt_s evt, // Endpoint handshake events
   output logic [15:0] rd_data, // Read word
   output logic rd_valid, // One-cycle pulse with rd_data
   output logic status_clear, // Pulse: ordinary status read clears bits
   output logic [3:0] status_ep, // Endpoint the status command addresses
   output logic [3:0] status_sel_ep, // Endpoint whose status is being read
   output logic [127:0] ep_cfg_flat, // All endpoint configs, endpoint 0 OUT low
   output logic [63:0] ep_size_flat, // Size codes from the table
   output logic [15:0] ep_active, // Enabled and allocated
   output logic fifo_alloc_start, // Pulse: allocation begins
   output logic fifo_invalidate, // Pulse: all FIFO contents lost
   output logic [6:0] usb_address_field, // Address in use on the bus
   output logic device_enable, // Device responds on the bus
   output logic dma_width_sel,
   output logic suspend_trigger, // Pulse: enter suspend
   output logic soft_pullup_enable,
   output logic irq_out // Gated endpoint interrupt
);
   // Host port handshake, as seen from inside the bank:
   // - a command strobe latches the code and arms the data phase
   // - the next write strobe or read request completes the command
   // - a data strobe with no armed command is dropped on the floor
   // - each register is one byte, so one word always ends a command
   // - in a 16-bit port the upper write byte is simply not looked at
   // - reads put the byte in the low half and zero in the upper half
   // Keeping the whole bank in one struct lets one comb block own
   // every next value, so no field can be forgotten on a path.
   // The trade-off is a wide register copy, which synthesis trims.
   // Whole state in one struct
   typedef struct packed {
      udcr_pkg::udcr_state_e state;
      logic [7:0] cmd;
      logic [15:0][7:0] ep_cfg;
      logic [15:0] seq_seen; // Endpoints written since endpoint 15 was last written
      logic allocated;
      logic [7:0] addr_reg; // Software view
      logic [6:0] addr_live; // Address in use
      logic dev_en_live;
      logic addr_pending; // Written address waits for status acknowledge
      logic [7:0] mode;
      logic [15:0] rd_data;
      logic rd_valid;
      logic status_clear;
      logic [3:0] status_ep;
      logic alloc_start;
      logic invalidate;
      logic suspend;
      logic irq;
      logic [63:0] size;
   } udcr_state_s;

   udcr_state_s s_q;
   udcr_state_s s_d;
   logic [1:0] rst_sync_q; // Reset release chain, kept outside the state struct
   logic rst_n; // Synchronised reset
   logic [3:0] cmd_ep;
   logic [3:0] cmd_grp;

   // Reset enters at once but leaves on a clock edge, so no flop
   // sees its release in the middle of a setup window.
   // The chain has its own process: sharing a variable with the
   // state register would give that variable two drivers.
   // Reset enters asynchronously, released through two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];
   assign cmd_ep = s_q.cmd[3:0];
   assign cmd_grp = s_q.cmd[7:4];

   // The comb block below works in this order:
   // - pulses default low, so each lasts exactly one cycle
   // - the command phase, then the data phase of an armed command
   // - the status acknowledge that commits a pending address
   // - the bus reset, last, so it wins over anything in the same cycle
   // - the size lookup from the new values, the interrupt path from the old ones
   // A bus reset that meets a register write keeps the reset result;
   // the host must redo the write after enumeration restarts anyway.
   // Next-state logic
   always_comb begin
      logic [7:0] wbyte;
      logic [7:0] old;
      logic bus_evt;
      wbyte = host.wr_data[7:0]; // Upper byte of a word is dropped
      old = 8'h00;
      bus_evt = 1'b0;
      s_d = s_q;
      s_d.rd_valid = 1'b0;
      s_d.status_clear = 1'b0;
      s_d.alloc_start = 1'b0;
      s_d.invalidate = 1'b0;
      s_d.suspend = 1'b0;
      // Command phase latches the code
      if (host.cmd_valid) begin
         s_d.cmd = host.cmd_code;
         s_d.state = udcr_pkg::UDCR_WAIT_WR;
      end
      case (s_q.state)
         udcr_pkg::UDCR_IDLE: begin
            s_d.rd_data = s_q.rd_data; // Hold last read
         end
         udcr_pkg::UDCR_WAIT_WR: begin
            // Each register here is one byte, so one word ends the transfer
            if (host.wr_valid && !host.cmd_valid) begin
               s_d.state = udcr_pkg::UDCR_IDLE;
               if (s_q.cmd[7:4] == udcr_pkg::CMD_EPCFG_WR_BASE[7:4]) begin
                  old = s_q.ep_cfg[cmd_ep];
                  s_d.ep_cfg[cmd_ep] = wbyte;
                  s_d.seq_seen[cmd_ep] = 1'b1;
                  // Any change touching memory after allocation drops all data
                  if (s_q.allocated && ((old[udcr_pkg::EPC_FIFO_EN] != wbyte[udcr_pkg::EPC_FIFO_EN])
                      || (old[3:0] != wbyte[3:0]) || (old[udcr_pkg::EPC_DBL] != wbyte[udcr_pkg::EPC_DBL]))) begin
                     s_d.invalidate = 1'b1; // Memory map stays; only contents are lost
                  end
                  // Allocation only once endpoints 0-14 have all been written, in any order, then endpoint 15
                  if (cmd_ep == udcr_pkg::EP_LAST) begin
                     if (&s_q.seq_seen[14:0]) begin
                        s_d.alloc_start = 1'b1;
                        s_d.allocated = 1'b1;
                     end
                     s_d.seq_seen = 16'h0000;
                  end
               end else if (s_q.cmd == udcr_pkg::CMD_ADDR_WR) begin
                  s_d.addr_reg = wbyte;
                  s_d.addr_pending = 1'b1; // Old address stays until acknowledged
               end else if (s_q.cmd == udcr_pkg::CMD_MODE_WR) begin
                  s_d.mode = wbyte;
                  // Falling suspend bit after a one triggers suspend
                  if (s_q.mode[udcr_pkg::MOD_SUSP] && !wbyte[udcr_pkg::MOD_SUSP]) begin
                     s_d.suspend = 1'b1;
                  end
               end
            end
            // Reads answer the read strobe; upper byte left at zero, meaningless
            if (host.rd_req && !host.cmd_valid) begin
               s_d.state = udcr_pkg::UDCR_IDLE;
               s_d.rd_valid = 1'b1;
               s_d.rd_data = 16'h0000;
               if (cmd_grp == udcr_pkg::CMD_EPCFG_RD_BASE[7:4]) begin
                  s_d.rd_data[7:0] = s_q.ep_cfg[cmd_ep];
               end else if (s_q.cmd == udcr_pkg::CMD_ADDR_RD) begin
                  s_d.rd_data[7:0] = s_q.addr_reg;
               end else if (s_q.cmd == udcr_pkg::CMD_MODE_RD) begin
                  s_d.rd_data[7:0] = s_q.mode;
               end else if (cmd_grp == udcr_pkg::CMD_STATUS_RD_BASE[7:4]) begin
                  s_d.rd_data[7:0] = ep_status_in;
                  s_d.status_clear = 1'b1; // Ordinary read clears
               end else if (cmd_grp == udcr_pkg::CMD_STATUS_CHK_BASE[7:4]) begin
                  s_d.rd_data[7:0] = ep_status_in; // Copy only, nothing cleared
               end
            end
         end
         udcr_pkg::UDCR_ALLOC: begin
            s_d.state = udcr_pkg::UDCR_IDLE;
         end
         default: begin
            s_d.state = udcr_pkg::UDCR_IDLE;
         end
      endcase
      s_d.status_ep = cmd_ep;
      // Commit pending address on status acknowledge
      if (status_ack && s_q.addr_pending) begin
         s_d.addr_live = s_q.addr_reg[6:0];
         s_d.dev_en_live = s_q.addr_reg[udcr_pkg::ADR_DEV_EN];
         s_d.addr_pending = 1'b0;
      end
      // Bus reset: endpoints off, address zero and enabled, register kept
      if (usb_bus_reset) begin
         bus_evt = 1'b1;
         for (int i = 0; i < udcr_pkg::NUM_EP; i++) begin
            s_d.ep_cfg[i][udcr_pkg::EPC_FIFO_EN] = 1'b0;
         end
         s_d.allocated = 1'b0;
         s_d.addr_live = 7'h00;
         s_d.dev_en_live = 1'b1;
         s_d.addr_pending = 1'b0;
         s_d.mode = s_d.mode & udcr_pkg::MOD_BUSRST_KEEP;
      end
      // Size lookup per endpoint
      for (int i = 0; i < udcr_pkg::NUM_EP; i++) begin
         s_d.size[i*4 +: 4] = FIFO_SIZE_TABLE[s_d.ep_cfg[i][3:0]*4 +: 4];
      end
      // The interrupt is a level for one cycle per event, not sticky:
      // a collector outside this bank latches and clears it.
      // Type is looked up for the endpoint that the event names,
      // using the configuration before this cycle's write lands.
      // Interrupt source follows debug mode; global enable gates it
      if (s_q.mode[udcr_pkg::MOD_DBG]) begin
         s_d.irq = s_q.mode[udcr_pkg::MOD_IRQ_EN] && (evt.nak_evt || evt.err_evt);
      end else if (s_q.ep_cfg[evt.ep_idx][udcr_pkg::EPC_ISO]) begin
         s_d.irq = s_q.mode[udcr_pkg::MOD_IRQ_EN] && evt.xfer_evt;
      end else begin
         s_d.irq = s_q.mode[udcr_pkg::MOD_IRQ_EN] && evt.ack_evt;
      end
      if (bus_evt) begin
         s_d.irq = 1'b0;
      end
   end

   // Every field is registered here from the comb copy.
   // Reset values are constants only; no field depends on an input
   // while reset is low, which keeps the reset path free of logic.
   // State register, cleared to documented resets
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q.state <= udcr_pkg::UDCR_IDLE;
         s_q.cmd <= 8'h00;
         s_q.ep_cfg <= '0;
         s_q.seq_seen <= 16'h0000;
         s_q.allocated <= 1'b0;
         s_q.addr_reg <= udcr_pkg::ADR_RESET;
         s_q.addr_live <= 7'h00;
         s_q.dev_en_live <= 1'b0;
         s_q.addr_pending <= 1'b0;
         s_q.mode <= udcr_pkg::MOD_RESET;
         s_q.rd_data <= 16'h0000;
         s_q.rd_valid <= 1'b0;
         s_q.status_clear <= 1'b0;
         s_q.status_ep <= 4'h0;
         s_q.alloc_start <= 1'b0;
         s_q.invalidate <= 1'b0;
         s_q.suspend <= 1'b0;
         s_q.irq <= 1'b0;
         s_q.size <= '0;
      end else begin
         s_q.state <= s_d.state;
         s_q.cmd <= s_d.cmd;
         s_q.ep_cfg <= s_d.ep_cfg;
         s_q.seq_seen <= s_d.seq_seen;
         s_q.allocated <= s_d.allocated;
         s_q.addr_reg <= s_d.addr_reg;
         s_q.addr_live <= s_d.addr_live;
         s_q.dev_en_live <= s_d.dev_en_live;
         s_q.addr_pending <= s_d.addr_pending;
         s_q.mode <= s_d.mode;
         s_q.rd_data <= s_d.rd_data;
         s_q.rd_valid <= s_d.rd_valid;
         s_q.status_clear <= s_d.status_clear;
         s_q.status_ep <= s_d.status_ep;
         s_q.alloc_start <= s_d.alloc_start;
         s_q.invalidate <= s_d.invalidate;
         s_q.suspend <= s_d.suspend;
         s_q.irq <= s_d.irq;
         s_q.size <= s_d.size;
      end
   end

   // Outputs straight from state flops
   assign rd_data = s_q.rd_data;
   assign rd_valid = s_q.rd_valid;
   assign status_clear = s_q.status_clear;
   assign status_ep = s_q.status_ep;
   assign status_sel_ep = s_q.cmd[3:0];
   assign ep_cfg_flat = s_q.ep_cfg;
   assign ep_size_flat = s_q.size;
   assign fifo_alloc_start = s_q.alloc_start;
   assign fifo_invalidate = s_q.invalidate;
   assign usb_address_field = s_q.addr_live;
   assign device_enable = s_q.dev_en_live;
   assign dma_width_sel = s_q.mode[udcr_pkg::MOD_DMA_WD];
   assign suspend_trigger = s_q.suspend;
   assign irq_out = s_q.irq;

   // The pull-up follows the mode bit written in the same cycle, so
   // it appears together with the other mode outputs.
   // An external resistor flag overrides the bit from the next clock edge.
   // Pull-up flop honours the external resistor flag
   logic pullup_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pullup_q <= 1'b0;
      end else begin
         pullup_q <= s_d.mode[udcr_pkg::MOD_PULLUP] && !external_pullup_flag;
      end
   end
   assign soft_pullup_enable = pullup_q;

   // Taken from the next values, so a bus reset drops every endpoint
   // in the same cycle as the configuration bits themselves.
   // Active set: enabled and memory allocated
   logic [15:0] active_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_q <= 16'h0000;
      end else begin
         for (int i = 0; i < udcr_pkg::NUM_EP; i++) begin
            active_q[i] <= s_d.allocated && s_d.ep_cfg[i][udcr_pkg::EPC_FIFO_EN];
         end
      end
   end
   assign ep_active = active_q;
endmodule : udcr_regs
`default_nettype wire

// File: sim/udcr_host_mdl.sv
// Microcontroller model driving the command port
`timescale 1ns/1ns
`default_nettype none
module udcr_host_mdl (
   input wire logic clk,
   output var udcr_pkg::udcr_host_s host
);
   // Strobes idle from time zero
   initial host = '0;
   // Issues no buffer validate or clear commands at all
   // Command phase; the code lines scramble once the phase is over
   task cmd(input logic [7:0] c);
      @(posedge clk) #1;
      host.cmd_valid = 1'b1;
      host.cmd_code = c;
      @(posedge clk) #1;
      host.cmd_valid = 1'b0;
      host.cmd_code = ~c;
   endtask : cmd
   // One word carries a one-byte register in either port width
   task wr(input logic [7:0] c, input logic [15:0] d);
      cmd(c);
      host.wr_valid = 1'b1;
      host.wr_data = d;
      @(posedge clk) #1;
      host.wr_valid = 1'b0;
      host.wr_data = ~d;
   endtask : wr
   // Read word request after the command; answer lands one cycle on
   task rd(input logic [7:0] c);
      cmd(c);
      host.rd_req = 1'b1;
      @(posedge clk) #1;
      host.rd_req = 1'b0;
   endtask : rd
endmodule : udcr_host_mdl
`default_nettype wire

// File: sim/udcr_regs_chk.sv
// Port checker for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module udcr_regs_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire udcr_pkg::udcr_host_s host,
   input wire logic usb_bus_reset,
   input wire logic status_ack,
   input wire logic external_pullup_flag,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic [15:0] ep_active,
   input wire logic fifo_alloc_start,
   input wire logic [6:0] usb_address_field,
   input wire logic device_enable,
   input wire logic suspend_trigger,
   input wire logic soft_pullup_enable
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_rd_answer: assert property (rd_valid |-> $past(host.rd_req))
      else $error("read answer without request");
   a_rd_upper: assert property (rd_valid |-> rd_data[15:8] == 8'h00)
      else $error("upper read byte not zero");
   a_busrst_disable: assert property (usb_bus_reset |=> ep_active == 16'h0000)
      else $error("endpoint active after bus reset");
   a_busrst_addr: assert property (usb_bus_reset |=> usb_address_field == 7'h00 && device_enable)
      else $error("bus address not zero and enabled");
   a_addr_hold: assert property (!$past(status_ack) && !$past(usb_bus_reset) |-> $stable(usb_address_field))
      else $error("bus address moved without cause");
   a_pullup_gate: assert property (external_pullup_flag && $past(external_pullup_flag) |-> !soft_pullup_enable)
      else $error("soft pull-up with external pull-up");
   a_susp_pulse: assert property (suspend_trigger |-> $past(host.wr_valid) ##1 !suspend_trigger)
      else $error("suspend pulse malformed");
   a_alloc_cause: assert property (fifo_alloc_start |-> $past(host.wr_valid) && !$past(fifo_alloc_start))
      else $error("allocation pulse without write");
endmodule : udcr_regs_chk
bind udcr_regs udcr_regs_chk u_chk (.clk(clk), .resetn(resetn), .host(host), .usb_bus_reset(usb_bus_reset),
   .status_ack(status_ack), .external_pullup_flag(external_pullup_flag), .rd_data(rd_data), .rd_valid(rd_valid),
   .ep_active(ep_active), .fifo_alloc_start(fifo_alloc_start), .usb_address_field(usb_address_field),
   .device_enable(device_enable), .suspend_trigger(suspend_trigger), .soft_pullup_enable(soft_pullup_enable));
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk, resetn, bus_16bit, usb_bus_reset, status_ack, external_pullup_flag, clr_seen;
   logic rd_valid, status_clear, fifo_alloc_start, fifo_invalidate, device_enable;
   logic dma_width_sel, suspend_trigger, soft_pullup_enable, irq_out;
   logic [7:0] ep_status_in;
   logic [15:0] rd_data, ep_active;
   logic [3:0] status_ep, status_sel_ep;
   logic [127:0] ep_cfg_flat;
   logic [63:0] ep_size_flat;
   logic [6:0] usb_address_field;
   udcr_pkg::udcr_evt_s evt;
   udcr_pkg::udcr_host_s host;
   logic [7:0] cfg [16]; // Configuration written per endpoint
   logic [15:0] exp_q [$]; // Expected read words, oldest first
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   // Mode, event and outcome per interrupt case; event byte is ack,nak,err,xfer,index
   localparam logic [7:0] IRQ_MODE [5] = '{8'h08, 8'h08, 8'h0c, 8'h0c, 8'h04};
   localparam logic [7:0] IRQ_EVT [5] = '{8'h80, 8'h40, 8'h40, 8'h20, 8'h40};
   localparam logic [4:0] IRQ_EXP = 5'b01101;
   localparam logic [7:0] INV_XOR [3] = '{8'h80, 8'h00, 8'h10};
   udcr_regs DUT (.clk(clk), .resetn(resetn), .host(host), .bus_16bit(bus_16bit), .usb_bus_reset(usb_bus_reset),
      .status_ack(status_ack), .external_pullup_flag(external_pullup_flag), .ep_status_in(ep_status_in),
      .evt(evt), .rd_data(rd_data), .rd_valid(rd_valid), .status_clear(status_clear), .status_ep(status_ep),
      .status_sel_ep(status_sel_ep), .ep_cfg_flat(ep_cfg_flat), .ep_size_flat(ep_size_flat),
      .ep_active(ep_active), .fifo_alloc_start(fifo_alloc_start), .fifo_invalidate(fifo_invalidate),
      .usb_address_field(usb_address_field), .device_enable(device_enable), .dma_width_sel(dma_width_sel),
      .suspend_trigger(suspend_trigger), .soft_pullup_enable(soft_pullup_enable), .irq_out(irq_out));
   udcr_host_mdl mdl (.clk(clk), .host(host));
   task check(input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   // Note the expected word, then let the model read
   task rd(input logic [7:0] c, input logic [7:0] v);
      exp_q.push_back({8'h00, v});
      mdl.rd(c);
   endtask : rd
   // Pulse bus reset (k=0) or status acknowledge (k=1) for one cycle
   task strobe(input int k);
      @(posedge clk) #1;
      if (k == 0) usb_bus_reset = 1'b1;
      else status_ack = 1'b1;
      @(posedge clk) #1;
      usb_bus_reset = 1'b0;
      status_ack = 1'b0;
   endtask : strobe
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Read watcher and hang guard; a stray answer counts as a mismatch
   always @(negedge clk) begin
      cyc++;
      if (status_clear) clr_seen <= 1'b1;
      if (rd_valid && exp_q.size() == 0) bad_count++;
      else if (rd_valid) check(rd_data, exp_q.pop_front());
      if (cyc == 4000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      resetn = 1'b0;
      bus_16bit = 1'b1;
      usb_bus_reset = 1'b0;
      status_ack = 1'b0;
      external_pullup_flag = 1'b0;
      ep_status_in = 8'h00;
      evt = '0;
      clr_seen = 1'b0;
      void'($urandom(72874));
      repeat (3) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (3) @(posedge clk);
      rd(udcr_pkg::CMD_EPCFG_RD_BASE, 8'h00);
      rd(udcr_pkg::CMD_ADDR_RD, 8'h00);
      rd(udcr_pkg::CMD_MODE_RD, 8'h00);
      $display("test reset done");
      // Full sequence, control endpoints included; upper byte is noise
      for (int i = 0; i < 16; i++) begin
         cfg[i] = 8'($urandom) | 8'h80;
         if (i < 2) cfg[i][4] = 1'b0;
         mdl.wr(udcr_pkg::CMD_EPCFG_WR_BASE + 8'(i), {8'($urandom), cfg[i]});
         check({15'h0, fifo_alloc_start}, {15'h0, i == 15});
      end
      for (int i = 0; i < 16; i++) begin
         rd(udcr_pkg::CMD_EPCFG_RD_BASE + 8'(i), cfg[i]);
         check({8'h0, ep_cfg_flat[8*i +: 8]}, {8'h0, cfg[i]});
         check({12'h0, ep_size_flat[4*i +: 4]}, {12'h0, cfg[i][3:0]});
         check({15'h0, ep_active[i]}, 16'h0001);
      end
      // Disable, re-enable, then a type-only change that keeps memory
      for (int i = 0; i < 3; i++) begin
         mdl.wr(8'h25, {8'h00, cfg[5] ^ INV_XOR[i]});
         check({15'h0, fifo_invalidate}, {15'h0, i < 2});
      end
      $display("test endpoint config done");
      // Address written first, then the status stage completes
      mdl.wr(udcr_pkg::CMD_ADDR_WR, 16'hff85);
      check({9'h0, usb_address_field}, 16'h0000);
      rd(udcr_pkg::CMD_ADDR_RD, 8'h85);
      strobe(1);
      check({8'h0, device_enable, usb_address_field}, 16'h0085);
      strobe(0);
      check({8'h0, device_enable, usb_address_field}, 16'h0080);
      check(ep_active, 16'h0000);
      rd(udcr_pkg::CMD_ADDR_RD, 8'h85);
      $display("test address done");
      mdl.wr(udcr_pkg::CMD_MODE_WR, 16'hff8d);
      check({14'h0, dma_width_sel, soft_pullup_enable}, 16'h0003);
      rd(udcr_pkg::CMD_MODE_RD, 8'h8d);
      external_pullup_flag = 1'b1;
      repeat (2) @(posedge clk) #1;
      check({15'h0, soft_pullup_enable}, 16'h0000);
      external_pullup_flag = 1'b0;
      // Suspend takes a one write followed by a zero write
      mdl.wr(udcr_pkg::CMD_MODE_WR, 16'h00a0);
      check({15'h0, suspend_trigger}, 16'h0000);
      mdl.wr(udcr_pkg::CMD_MODE_WR, 16'h0080);
      check({15'h0, suspend_trigger}, 16'h0001);
      mdl.wr(udcr_pkg::CMD_MODE_WR, 16'h00ff);
      strobe(0);
      rd(udcr_pkg::CMD_MODE_RD, udcr_pkg::MOD_BUSRST_KEEP);
      for (int i = 0; i < 5; i++) begin
         mdl.wr(udcr_pkg::CMD_MODE_WR, {8'h00, IRQ_MODE[i]});
         @(posedge clk) #1;
         evt = IRQ_EVT[i];
         @(posedge clk) #1;
         evt = '0;
         check({15'h0, irq_out}, {15'h0, IRQ_EXP[i]});
      end
      $display("test mode done");
      ep_status_in = 8'($urandom);
      clr_seen = 1'b0;
      rd(udcr_pkg::CMD_STATUS_CHK_BASE + 8'h03, ep_status_in);
      @(posedge clk) #1;
      check({15'h0, clr_seen}, 16'h0000);
      check({12'h0, status_sel_ep}, 16'h0003);
      rd(udcr_pkg::CMD_STATUS_RD_BASE + 8'h03, ep_status_in);
      @(posedge clk) #1;
      check({11'h0, clr_seen, status_ep}, 16'h0013);
      $display("test status done");
      print_verdict();
   end
endmodule : tb
`default_nettype wire
